/* File: ogb_core_src.sv */
// core-side source offering parallel words
`timescale 1ns/1ps
module ogb_core_src
	import ogb_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic ready_in,
	output logic valid_out,
	output ogb_word_t word_out
);
	ogb_word_t q[$];
	initial begin
		valid_out = 1'b0;
		word_out = '0;
	end
	// hold each word until taken, then offer the next
	always @(posedge ref_clk_in) begin
		if (valid_out && ready_in)
			void'(q.pop_front());
		valid_out <= q.size() != 0;
		if (q.size() != 0)
			word_out <= q[0];
		else
			word_out.data <= ~word_out.data; // released data keeps moving
	end
endmodule // ogb_core_src

/* File: ogb_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module ogb_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [CNT_W-1:0] count;
		logic ready;
		logic valid;
	} fifo_state_t;

	fifo_state_t state_reg;
	fifo_state_t state_next;
	logic push;
	logic pop;

	// pointer advance with wrap
	function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
		bump = (p == PTR_LAST) ? '0 : p + 1'b1;
	endfunction

	// next state: push, pop, honest full and empty flags
	always_comb begin
		state_next = state_reg;
		push = in_valid_in && state_reg.ready;
		pop = out_ready_in && state_reg.valid;
		if (push) begin
			state_next.mem[state_reg.wr_ptr] = in_data_in;
			state_next.wr_ptr = bump(state_reg.wr_ptr);
		end
		if (pop) begin
			state_next.rd_ptr = bump(state_reg.rd_ptr);
		end
		if (push && !pop) begin
			state_next.count = state_reg.count + 1'b1;
		end else if (pop && !push) begin
			state_next.count = state_reg.count - 1'b1;
		end
		state_next.ready = (state_next.count != CNT_FULL);
		state_next.valid = (state_next.count != '0);
	end

	// state register
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign in_ready_out = state_reg.ready;
	assign out_valid_out = state_reg.valid;
	assign out_data_out = state_reg.mem[state_reg.rd_ptr];

endmodule // ogb_fifo

/* File: ogb_gearbox.sv */
// parallel-to-serial output gearbox with three pipeline stages
`timescale 1ns/1ps
module ogb_gearbox
	import ogb_pkg::*;
#(
	parameter int FIFO_DEPTH = OGB_FIFO_DEPTH
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire ogb_mode_t mode_in,
	input wire logic [OGB_DATA_W-1:0] par_data_in,
	input wire logic par_valid_in,
	output logic par_ready_out,
	output ogb_ddr_pair_t lower_q_out,
	output ogb_ddr_pair_t upper_q_out
);
	typedef struct packed {
		logic hold_valid;
		ogb_word_t hold;
		logic run;
		ogb_mode_t mode;
		logic [OGB_DATA_W-1:0] shift;
		logic [OGB_CNT_W-1:0] left;
		ogb_ddr_pair_t lower;
		ogb_ddr_pair_t upper;
	} ogb_state_t;

	ogb_state_t state_reg;
	ogb_state_t state_next;
	ogb_word_t fifo_word;
	logic fifo_valid;
	logic hold_free;
	logic take;

	// fast cycles a word occupies in a mode
	function automatic logic [OGB_CNT_W-1:0] cycles_for(input ogb_mode_t m);
		case (m)
			OGB_VIDEO_SEVEN: cycles_for = OGB_CYC_VIDEO;
			OGB_RATIO_EIGHT_DDR_MODE: cycles_for = OGB_CYC_EIGHT;
			OGB_RATIO_FOUR_DDR_MODE: cycles_for = OGB_CYC_FOUR;
			default: cycles_for = OGB_CYC_FOUR;
		endcase
	endfunction

	// stage one: word and mode captured together into the buffer
	ogb_fifo #(
		.WIDTH($bits(ogb_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.in_data_in({mode_in, par_data_in}),
		.in_valid_in(par_valid_in),
		.in_ready_out(par_ready_out),
		.out_data_out(fifo_word),
		.out_valid_out(fifo_valid),
		.out_ready_in(hold_free)
	);

	// shifter takes a new word when idle or on its last cycle
	assign take = !state_reg.run || (state_reg.left == OGB_CYC_LAST);
	assign hold_free = !state_reg.hold_valid || take; // back-pressure into the fifo

	// stages two and three
	always_comb begin
		state_next = state_reg;
		state_next.lower = OGB_PAIR_IDLE;
		state_next.upper = OGB_PAIR_IDLE;
		// stage three: emit from the shifter, lowest bit first
		if (state_reg.run) begin
			case (state_reg.mode)
				OGB_VIDEO_SEVEN: begin
					// one bit per cycle, held over both halves
					state_next.lower.rise = state_reg.shift[OGB_LOWER_LSB];
					state_next.lower.fall = state_reg.shift[OGB_LOWER_LSB];
					state_next.shift = state_reg.shift >> 1;
				end
				OGB_RATIO_EIGHT_DDR_MODE: begin
					state_next.lower.rise = state_reg.shift[OGB_LOWER_LSB];
					state_next.lower.fall = state_reg.shift[OGB_LOWER_LSB+1];
					state_next.shift = state_reg.shift >> 2;
				end
				OGB_RATIO_FOUR_DDR_MODE: begin
					// two independent lanes from each nibble
					state_next.lower.rise = state_reg.shift[OGB_LOWER_LSB];
					state_next.lower.fall = state_reg.shift[OGB_LOWER_LSB+1];
					state_next.upper.rise = state_reg.shift[OGB_UPPER_LSB];
					state_next.upper.fall = state_reg.shift[OGB_UPPER_LSB+1];
					state_next.shift[OGB_LANE_W-1:0] =
						state_reg.shift[OGB_LANE_W-1:0] >> 2;
					state_next.shift[OGB_DATA_W-1:OGB_LANE_W] =
						state_reg.shift[OGB_DATA_W-1:OGB_LANE_W] >> 2;
				end
				default: begin
					state_next.shift = '0;
				end
			endcase
			state_next.left = state_reg.left - 1'b1;
			if (take) begin
				state_next.run = 1'b0;
			end
		end
		// stage three load from stage two
		if (take && state_reg.hold_valid) begin
			state_next.run = 1'b1;
			state_next.mode = state_reg.hold.mode;
			state_next.shift = state_reg.hold.data;
			state_next.left = cycles_for(state_reg.hold.mode);
			state_next.hold_valid = 1'b0;
		end
		// stage two: hand the buffered word to the shifting side
		if (hold_free && fifo_valid) begin
			state_next.hold_valid = 1'b1;
			state_next.hold = fifo_word;
		end
	end

	// state register; reset clears every stage
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign lower_q_out = state_reg.lower;
	assign upper_q_out = state_reg.upper;

endmodule // ogb_gearbox

/* File: ogb_gearbox_chk.sv */
// port checker for the output gearbox
`timescale 1ns/1ps
module ogb_gearbox_chk
	import ogb_pkg::*;
#(parameter int FIFO_DEPTH = 8) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire ogb_mode_t mode_in,
	input wire logic [7:0] par_data_in,
	input wire logic par_valid_in,
	input wire logic par_ready_out,
	input wire ogb_ddr_pair_t lower_q_out,
	input wire ogb_ddr_pair_t upper_q_out
);
	logic [6:0] gap_reg;
	logic idle;
	// accept after a long quiet spell, so the pipeline is drained
	assign idle = par_valid_in && par_ready_out && gap_reg == 7'h7f;
	// cycles since the last accept, saturating
	always_ff @(posedge ref_clk_in)
		gap_reg <= (!rst_n_in || par_valid_in && par_ready_out) ? 7'h0 : gap_reg + 7'(gap_reg != 7'h7f);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	rst_clear_a: assert property (disable iff (1'b0) !rst_n_in |=> {lower_q_out, upper_q_out} == 4'h0)
		else $error("outputs not cleared");
	ready_rise_a: assert property ($rose(rst_n_in) |-> !par_ready_out ##1 par_ready_out)
		else $error("ready after reset");
	video_first_a: assert property (idle && mode_in == OGB_VIDEO_SEVEN |=> (lower_q_out == 2'h0) [*3]
		##1 lower_q_out == {2{$past(par_data_in[0], 4)}}) else $error("video first bit");
	video_upper_a: assert property (idle && mode_in == OGB_VIDEO_SEVEN |-> ##4 (upper_q_out == 2'h0) [*7])
		else $error("upper lane busy");
	eight_first_a: assert property (idle && mode_in == OGB_RATIO_EIGHT_DDR_MODE |-> ##4
		lower_q_out == {$past(par_data_in[0], 4), $past(par_data_in[1], 4)}) else $error("eight order");
	lane_first_a: assert property (idle && mode_in == OGB_RATIO_FOUR_DDR_MODE |-> ##4
		upper_q_out == {$past(par_data_in[4], 4), $past(par_data_in[5], 4)}) else $error("upper lane");
	cover property (idle && mode_in == OGB_VIDEO_SEVEN);
	cover property (idle && mode_in == OGB_RATIO_FOUR_DDR_MODE);
	cover property (idle && mode_in == OGB_RATIO_EIGHT_DDR_MODE);
	cover property (par_valid_in && !par_ready_out);
endmodule // ogb_gearbox_chk
bind ogb_gearbox ogb_gearbox_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_ogb_gearbox_chk (.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in), .mode_in(mode_in), .par_data_in(par_data_in), .par_valid_in(par_valid_in),
	.par_ready_out(par_ready_out), .lower_q_out(lower_q_out), .upper_q_out(upper_q_out));

/* File: ogb_gearbox_test.sv */
// self-checking bench for the output gearbox
`timescale 1ns/1ps
module ogb_gearbox_test;
	import ogb_pkg::*;
	logic ref_clk_in, rst_n_in, par_valid_in, par_ready_out;
	ogb_word_t w;
	ogb_ddr_pair_t lower_q_out, upper_q_out;
	int mismatches = 0, total_checks = 0, cyc = 0;
	ogb_core_src i_ogb_core_src (.ref_clk_in(ref_clk_in), .ready_in(par_ready_out), .valid_out(par_valid_in),
		.word_out(w));
	ogb_gearbox i_ogb_gearbox (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .mode_in(w.mode),
		.par_data_in(w.data), .par_valid_in(par_valid_in), .par_ready_out(par_ready_out),
		.lower_q_out(lower_q_out), .upper_q_out(upper_q_out));
	// clock
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	// hang guard
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [5:0] got, input logic [5:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	// expected {lower, upper} for pair k of a word
	function automatic logic [3:0] pair(ogb_mode_t m, logic [7:0] x, int k);
		if (m == OGB_VIDEO_SEVEN)
			return {x[k], x[k], 2'h0};
		return {x[2*k], x[2*k+1], m == OGB_RATIO_FOUR_DDR_MODE ? {x[4+2*k], x[5+2*k]} : 2'h0};
	endfunction
	function automatic int len(ogb_mode_t m);
		return m == OGB_VIDEO_SEVEN ? 7 : m == OGB_RATIO_EIGHT_DDR_MODE ? 4 : 2;
	endfunction
	// n words back to back, whole serial stream compared
	task automatic stream(input int n, input ogb_mode_t m, input logic [7:0] d, input logic full_exp);
		logic full;
		int t;
		full = 1'b0;
		t = 0;
		repeat (130) @(posedge ref_clk_in);
		for (int i = 0; i < n; i++)
			i_ogb_core_src.q.push_back('{m, d + 8'(i * 53)});
		// wait off the edge until the offer stands with ready; the accept is the next edge
		#1;
		while (!(par_valid_in && par_ready_out) && t < 50) begin
			@(posedge ref_clk_in);
			#1;
			t++;
		end
		chk({5'h0, t < 50}, 6'h1, "word not accepted");
		repeat (4) @(posedge ref_clk_in);
		for (int i = 0; i < n * len(m); i++) begin
			#1;
			chk({2'h0, lower_q_out, upper_q_out}, {2'h0, pair(m, d + 8'(i / len(m) * 53), i % len(m))}, "pair");
			full |= !par_ready_out;
			@(posedge ref_clk_in);
		end
		#1;
		chk({lower_q_out, upper_q_out, 1'b0, full}, {5'h0, full_exp}, "full or idle");
	endtask
	// reset in mid-stream clears all stages
	task automatic reset_mid();
		repeat (4) i_ogb_core_src.q.push_back('{OGB_RATIO_EIGHT_DDR_MODE, 8'hff});
		repeat (8) @(posedge ref_clk_in);
		rst_n_in <= 1'b0;
		i_ogb_core_src.q.delete();
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		#1;
		chk({lower_q_out, upper_q_out, 1'b0, par_ready_out}, 6'h0, "reset");
		repeat (2) @(posedge ref_clk_in);
		#1;
		chk({lower_q_out, upper_q_out, 1'b0, par_ready_out}, 6'h1, "ready or leftover word");
	endtask
	// closing report
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		rst_n_in = 1'b0;
		repeat (5) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		stream(1, OGB_VIDEO_SEVEN, 8'hb4, 1'b0);
		stream(1, OGB_RATIO_EIGHT_DDR_MODE, 8'hb4, 1'b0);
		stream(6, OGB_RATIO_FOUR_DDR_MODE, 8'h3c, 1'b0);
		stream(12, OGB_VIDEO_SEVEN, 8'hc9, 1'b1);
		reset_mid();
		tally_and_finish();
	end
endmodule // ogb_gearbox_test

/* File: ogb_pkg.sv */
// shared constants and types for the output serializer gearbox
package ogb_pkg;

	localparam int OGB_DATA_W = 8;
	localparam int OGB_FIFO_DEPTH = 8;
	localparam int OGB_LANE_W = 4;
	localparam int OGB_CNT_W = 3;

	// fast cycles per word for each mode, and the count left on a word's last cycle
	localparam logic [OGB_CNT_W-1:0] OGB_CYC_VIDEO = 3'h7;
	localparam logic [OGB_CNT_W-1:0] OGB_CYC_EIGHT = 3'h4;
	localparam logic [OGB_CNT_W-1:0] OGB_CYC_FOUR = 3'h2;
	localparam logic [OGB_CNT_W-1:0] OGB_CYC_LAST = 3'h1;

	// bit positions of the first bits of each lane
	localparam int OGB_LOWER_LSB = 0;
	localparam int OGB_UPPER_LSB = 4;

	typedef enum logic [1:0] {
		OGB_VIDEO_SEVEN,
		OGB_RATIO_EIGHT_DDR_MODE,
		OGB_RATIO_FOUR_DDR_MODE
	} ogb_mode_t;

	// one bit per clock half
	typedef struct packed {
		logic rise;
		logic fall;
	} ogb_ddr_pair_t;

	// word as it travels through the fifo
	typedef struct packed {
		ogb_mode_t mode;
		logic [OGB_DATA_W-1:0] data;
	} ogb_word_t;

	localparam ogb_ddr_pair_t OGB_PAIR_IDLE = '{rise: 1'b0, fall: 1'b0};

endpackage
